// ==== rtl/pwt_pkg.sv ====
// constants and types shared by the periodic wakeup timer
package pwt_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_CONTROL   = 10'h2f2;
    localparam logic [9:0] IDX_TRIM      = 10'h2f3;
    localparam logic [9:0] IDX_RATE_HIGH = 10'h2f4;
    localparam logic [9:0] IDX_RATE_LOW  = 10'h2f5;
    localparam logic [9:0] IDX_RESERVED  = 10'h2f6;

    // control register field positions
    localparam int CTL_CLK_SEL = 7;
    localparam int CTL_WAVE    = 4;
    localparam int CTL_EXT_EN  = 3;
    localparam int CTL_FE      = 2;
    localparam int CTL_IE      = 1;
    localparam int CTL_FLAG    = 0;

    // trim field position inside its byte
    localparam int TRIM_LSB = 2;
    localparam int TRIM_W   = 6;

    // reset values
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [5:0]  TRIM_RESET    = 6'h00;
    localparam logic [15:0] RATE_RESET    = 16'h0000;

    // timing: oscillator half-period and clock period in ns
    localparam int OSC_HALF_PERIOD_NS = 100000;
    localparam int CLK_PERIOD_NS      = 4;
    localparam int OSC_HALF_CYCLES    = OSC_HALF_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TRIM_STEP_CYCLES   = 16;

    typedef enum logic [2:0] {
        PWT_SEL_NONE,
        PWT_SEL_CONTROL,
        PWT_SEL_TRIM,
        PWT_SEL_RATE_HIGH,
        PWT_SEL_RATE_LOW,
        PWT_SEL_RESERVED
    } pwt_sel_t;

    typedef struct packed {
        logic clk_sel;
        logic wave_sel;
        logic ext_en;
        logic feature_en;
        logic irq_en;
    } pwt_ctrl_t;

endpackage : pwt_pkg

// ==== rtl/pwt_timer.sv ====
// periodic wakeup timer with apb register slave
//
// How it works
// - control bit 7 picks timer clock: 0 internal oscillator, 1 bus clock
// - clock select writable only while enable clear and not set same write
// - enable bit 2 starts counting; clearing it disables the timer
// - irq enable bit 1 makes flag raise an interrupt request
// - timeout flag bit 0 set whenever the configured period elapses
// - flag cleared only by writing one; writing zero leaves it
// - clear in same cycle as timeout wins; flag ends zero
// - wave select bit 4 set: square clock of twice the period on pin
// - wave select clear: high pulse of half minimum period each timeout
// - pin driven only while external enable bit 3 and timer enable set
// - trim register bits 7 to 2 hold six-bit oscillator trim
// - top trim bit lengthens; lower bits shorten by halving amounts
// - trim resets to zero or a preset value given by parameter
// - 16-bit rate in high and low bytes, writable only while disabled
// - oscillator source: period is 2 times rate plus one times 0.1 ms
// - bus source: period is 2 times rate plus one bus cycles
// - timer restarts by itself after each timeout
// - bus source with bus clock stopped freezes the count
`timescale 1ns/1ps
module pwt_timer #(
    parameter int          OSC_TICK_CYCLES = pwt_pkg::OSC_HALF_CYCLES,
    parameter int          TRIM_STEP       = pwt_pkg::TRIM_STEP_CYCLES,
    parameter logic [5:0]  TRIM_PRESET     = pwt_pkg::TRIM_RESET,
    parameter int          ADDR_W          = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              bus_clk_en,
    output logic                   timeout_irq,
    output logic                   wave_out,
    output logic                   wave_out_en
);

    localparam logic [15:0] OSC_BASE  = 16'(OSC_TICK_CYCLES);
    localparam logic [15:0] TRIM_UNIT = 16'(TRIM_STEP);

    pwt_pkg::pwt_ctrl_t ctrl_q;
    logic               flag_q;
    logic [5:0]         trim_q;
    logic [15:0]        rate_q;
    logic [15:0]        osc_div_q;
    logic [16:0]        period_cnt_q;
    logic               pulse_q;
    logic               toggle_q;
    logic               pready_q;
    logic               pslverr_q;
    logic [31:0]        prdata_q;
    logic               irq_q;
    logic               wave_q;
    logic               wave_en_q;

    pwt_pkg::pwt_sel_t  sel;
    logic               access;
    logic               wr_fire;
    logic               wr_byte;
    logic [7:0]         wbyte;
    logic [7:0]         rd_byte;
    logic [15:0]        osc_limit;
    logic               osc_tick;
    logic               unit_tick;
    logic               timeout;
    logic               flag_clear;
    logic               flag_d;
    logic [16:0]        period_cnt_d;
    logic [15:0]        osc_div_d;
    logic [15:0]        rate_d;
    pwt_pkg::pwt_ctrl_t ctrl_d;

    // decode a byte address to a register; unaligned goes unmapped
    function automatic pwt_pkg::pwt_sel_t decode(
        input logic [ADDR_W-1:0] addr
    );
        logic [9:0] idx;
        idx = addr[11:2];
        if (addr[1:0] != 2'b00) begin
            return pwt_pkg::PWT_SEL_NONE;
        end
        case (idx)
            pwt_pkg::IDX_CONTROL:   return pwt_pkg::PWT_SEL_CONTROL;
            pwt_pkg::IDX_TRIM:      return pwt_pkg::PWT_SEL_TRIM;
            pwt_pkg::IDX_RATE_HIGH: return pwt_pkg::PWT_SEL_RATE_HIGH;
            pwt_pkg::IDX_RATE_LOW:  return pwt_pkg::PWT_SEL_RATE_LOW;
            pwt_pkg::IDX_RESERVED:  return pwt_pkg::PWT_SEL_RESERVED;
            default:                return pwt_pkg::PWT_SEL_NONE;
        endcase
    endfunction : decode

    // oscillator half-period in clocks after trim
    // no floor: base must stay above 31 steps or the count wraps
    function automatic logic [15:0] trim_count(
        input logic [5:0]  tr,
        input logic [15:0] base,
        input logic [15:0] step
    );
        logic [15:0] c;
        c = base;
        if (tr[5]) begin
            c = c + (step << 5);
        end
        for (int k = 0; k < 5; k++) begin
            if (tr[k]) begin
                c = c - (step << k);
            end
        end
        return c;
    endfunction : trim_count

    // a committed byte write aimed at one register
    function automatic logic reg_wr(
        input logic              fire,
        input pwt_pkg::pwt_sel_t got,
        input pwt_pkg::pwt_sel_t want
    );
        return fire & (got == want);
    endfunction : reg_wr

    // control byte as software reads it; bits 6 and 5 read zero
    function automatic logic [7:0] ctrl_byte(
        input pwt_pkg::pwt_ctrl_t c,
        input logic               f
    );
        return {c.clk_sel, 2'b00, c.wave_sel, c.ext_en, c.feature_en,
                c.irq_en, f};
    endfunction : ctrl_byte

    // ---------------- bus slave ----------------
    assign sel     = decode(paddr);
    assign access  = psel & penable;
    // one wait state: writes land on the edge that sees pready high
    assign wr_fire = access & pwrite & pready_q;
    assign wr_byte = wr_fire & pstrb[0];
    assign wbyte   = pwdata[7:0];
    assign flag_clear = reg_wr(wr_byte, sel, pwt_pkg::PWT_SEL_CONTROL)
                        & wbyte[pwt_pkg::CTL_FLAG];

    always_comb begin
        case (sel)
            pwt_pkg::PWT_SEL_CONTROL:   rd_byte = ctrl_byte(ctrl_q, flag_q);
            pwt_pkg::PWT_SEL_TRIM:      rd_byte = {trim_q, 2'b00};
            pwt_pkg::PWT_SEL_RATE_HIGH: rd_byte = rate_q[15:8];
            pwt_pkg::PWT_SEL_RATE_LOW:  rd_byte = rate_q[7:0];
            default:                    rd_byte = 8'h00;
        endcase
    end

    // exactly one wait state: answer in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= access & ~pready_q;
        end
    end

    // unmapped or unaligned offsets answer with an error, write dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= access & ~pready_q
                         & (sel == pwt_pkg::PWT_SEL_NONE);
        end
    end

    // read data captured once and held until the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (access & ~pready_q & ~pwrite) begin
            prdata_q <= {24'h00_0000, rd_byte};
        end
    end

    // ---------------- registers ----------------
    // source may only move while stopped and not started by this write
    always_comb begin
        ctrl_d = ctrl_q;
        if (reg_wr(wr_byte, sel, pwt_pkg::PWT_SEL_CONTROL)) begin
            if (!ctrl_q.feature_en && !wbyte[pwt_pkg::CTL_FE]) begin
                ctrl_d.clk_sel = wbyte[pwt_pkg::CTL_CLK_SEL];
            end
            ctrl_d.wave_sel   = wbyte[pwt_pkg::CTL_WAVE];
            ctrl_d.ext_en     = wbyte[pwt_pkg::CTL_EXT_EN];
            ctrl_d.feature_en = wbyte[pwt_pkg::CTL_FE];
            ctrl_d.irq_en     = wbyte[pwt_pkg::CTL_IE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= pwt_pkg::pwt_ctrl_t'({
                pwt_pkg::CONTROL_RESET[pwt_pkg::CTL_CLK_SEL],
                pwt_pkg::CONTROL_RESET[pwt_pkg::CTL_WAVE:pwt_pkg::CTL_IE]});
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // trim is not locked: a change retunes a running oscillator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_q <= TRIM_PRESET;
        end else if (reg_wr(wr_byte, sel, pwt_pkg::PWT_SEL_TRIM)) begin
            trim_q <= wbyte[7:pwt_pkg::TRIM_LSB];
        end
    end

    // both halves stay frozen while the timer runs
    always_comb begin
        rate_d = rate_q;
        if (wr_byte && !ctrl_q.feature_en) begin
            if (sel == pwt_pkg::PWT_SEL_RATE_HIGH) begin
                rate_d[15:8] = wbyte;
            end
            if (sel == pwt_pkg::PWT_SEL_RATE_LOW) begin
                rate_d[7:0] = wbyte;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_q <= pwt_pkg::RATE_RESET;
        end else begin
            rate_q <= rate_d;
        end
    end

    // ---------------- time base ----------------
    assign osc_limit = trim_count(trim_q, OSC_BASE, TRIM_UNIT);
    assign osc_tick  = (osc_div_q >= osc_limit - 16'h0001);

    // oscillator stand-in: divider held in reset while not in use
    always_comb begin
        if (!ctrl_q.feature_en || ctrl_q.clk_sel || osc_tick) begin
            osc_div_d = 16'h0000;
        end else begin
            osc_div_d = osc_div_q + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_div_q <= 16'h0000;
        end else begin
            osc_div_q <= osc_div_d;
        end
    end

    // one unit is half the minimum period in either source
    assign unit_tick = ctrl_q.feature_en &
                       (ctrl_q.clk_sel ? bus_clk_en
                                       : osc_tick);
    assign timeout   = unit_tick & (period_cnt_q == {rate_q, 1'b1});

    // a stop or a timeout always leads into a full fresh period
    always_comb begin
        if (!ctrl_q.feature_en) begin
            period_cnt_d = 17'h0_0000;
        end else if (timeout) begin
            period_cnt_d = 17'h0_0000;
        end else if (unit_tick) begin
            period_cnt_d = period_cnt_q + 17'h0_0001;
        end else begin
            period_cnt_d = period_cnt_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_cnt_q <= 17'h0_0000;
        end else begin
            period_cnt_q <= period_cnt_d;
        end
    end

    // ---------------- flag and request ----------------
    // clear takes precedence over a timeout in the same cycle
    always_comb begin
        if (flag_clear) begin
            flag_d = 1'b0;
        end else if (timeout) begin
            flag_d = 1'b1;
        end else begin
            flag_d = flag_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= flag_q & ctrl_q.irq_en;
        end
    end

    // ---------------- external waveform ----------------
    // pulse lasts one unit, which is half of the shortest period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_q <= 1'b0;
        end else if (!ctrl_q.feature_en) begin
            pulse_q <= 1'b0;
        end else if (timeout) begin
            pulse_q <= 1'b1;
        end else if (unit_tick) begin
            pulse_q <= 1'b0;
        end
    end

    // flipping at each timeout gives a square wave of twice the period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            toggle_q <= 1'b0;
        end else if (!ctrl_q.feature_en) begin
            toggle_q <= 1'b0;
        end else if (timeout) begin
            toggle_q <= ~toggle_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_en_q <= 1'b0;
        end else begin
            wave_en_q <= ctrl_q.ext_en & ctrl_q.feature_en;
        end
    end

    // data forced low when not driven, so the pin never shows stale state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_q <= 1'b0;
        end else begin
            wave_q <= ctrl_q.ext_en & ctrl_q.feature_en &
                      (ctrl_q.wave_sel ? toggle_q : pulse_q);
        end
    end

    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign prdata      = prdata_q;
    assign timeout_irq = irq_q;
    assign wave_out    = wave_q;
    assign wave_out_en = wave_en_q;

endmodule : pwt_timer

// ==== test/pwt_timer_monitor.sv ====
// assertion checker bound to the periodic wakeup timer
`timescale 1ns/1ps
module pwt_timer_monitor #(parameter int ADDR_W = 12) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              timeout_irq,
    input wire logic              wave_out,
    input wire logic              wave_out_en
);
    logic ex_q, fe_q, ie_q;
    wire  ctl_wr = psel && penable && pready && pwrite && pstrb[0]
                   && paddr == ADDR_W'({pwt_pkg::IDX_CONTROL, 2'b00});
    // shadow of the enables, taken at the commit edge of a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) {ex_q, fe_q, ie_q} <= 3'h0;
        else if (ctl_wr) {ex_q, fe_q, ie_q} <= pwdata[3:1];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_wait: assert property (
        psel && penable && !pready |=> pready) else $error("late pready");
    a_ready_one_cycle: assert property (
        pready |=> !pready) else $error("pready held too long");
    a_rdata_upper: assert property (
        pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper");
    a_rdata_holds: assert property (
        !(psel && penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    a_irq_masked: assert property (
        $rose(timeout_irq) |-> $past(ie_q)) else $error("irq while masked");
    a_pin_off: assert property (
        !fe_q && !$past(fe_q) |-> !wave_out_en) else $error("pin on");
    a_pin_on: assert property (
        fe_q && ex_q && $past(fe_q && ex_q) |-> wave_out_en)
        else $error("pin off");
    a_wave_idle: assert property (
        !wave_out_en [*2] |-> !wave_out) else $error("wave while off");
endmodule : pwt_timer_monitor

bind pwt_timer pwt_timer_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .timeout_irq(timeout_irq),
    .wave_out(wave_out), .wave_out_en(wave_out_en));

// ==== test/tb_top.sv ====
// self-checking bench for the periodic wakeup timer
`timescale 1ns/1ps
module tb_top;
    localparam int          OSC   = 40;
    localparam logic [11:0] A_CTL = {pwt_pkg::IDX_CONTROL, 2'b00};
    localparam logic [11:0] A_TRM = {pwt_pkg::IDX_TRIM, 2'b00};
    localparam logic [11:0] A_LO  = {pwt_pkg::IDX_RATE_LOW, 2'b00};
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        bus_clk_en = 1, e, pready, pslverr;
    logic        timeout_irq, wave_out, wave_out_en;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, lfsr_q = 32'h00014b59;
    logic [7:0]  q, tv;
    int          err_total = 0, checks_done = 0, n, w, b, r;
    always #2 pclk = ~pclk;
    pwt_timer #(.OSC_TICK_CYCLES(OSC), .TRIM_STEP(1)) u_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(4'hf), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .bus_clk_en(bus_clk_en),
        .timeout_irq(timeout_irq), .wave_out(wave_out),
        .wave_out_en(wave_out_en));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    // clock cycles per internal oscillator unit, from trim
    function automatic int lim(input logic [5:0] t);
        lim = OSC + 32 * int'(t[5]);
        for (int k = 0; k < 5; k++) lim -= int'(t[k]) << k;
    endfunction : lim
    task automatic check(input string nm, input logic [15:0] s, x);
        checks_done++;
        if (s !== x) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, x, s);
        end
    endtask : check
    // leading edge keeps psel from being driven twice in one step
    task automatic apb(input logic wr_en, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= wr_en; paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] m, x);
        apb(0, a, 8'h00);
        check("read data", 16'(q & m), 16'(x));
    endtask : rd
    // k cycles of stopped bus clock before counting may advance
    task automatic cnt_irq(input int k);
        n = 0;
        do begin
            bus_clk_en <= (n >= k);
            @(posedge pclk);
            n++;
        end while (timeout_irq !== 1'b1 && n < 2000);
        bus_clk_en <= 1'b1;
    endtask : cnt_irq
    task automatic edge_t(input logic lvl, output int t);
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (wave_out !== lvl && t < 2000);
    endtask : edge_t
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (50000) @(posedge pclk);
        err_total++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 5; i++) rd(A_CTL + 12'(4 * i), 8'hff, 8'h00);
        apb(0, 12'hbdc, 8'h00);
        check("unmapped error", 16'(e), 16'h1);
        wr(A_TRM, 8'hff);
        rd(A_TRM, 8'hff, 8'hfc);
        $display("register test done");
        for (int i = 0; i < 4; i++) begin
            lfsr_q = nxt(lfsr_q);
            r = (i == 0) ? 0 : int'(lfsr_q[2:0]);
            wr(A_LO, 8'(r));
            wr(A_CTL, 8'h80);
            wr(A_CTL, 8'h86);
            cnt_irq(int'(lfsr_q[4:3]));
            check("bus period", 16'(n), 16'(2 * r + 4 + int'(lfsr_q[4:3])));
            wr(A_CTL, 8'h82);
            rd(A_CTL, 8'hff, 8'h83);
            wr(A_CTL, 8'h80);
            repeat (2) @(posedge pclk);
            check("masked irq", 16'(timeout_irq), 16'h0);
            wr(A_CTL, 8'h81);
            rd(A_CTL, 8'hff, 8'h80);
        end
        wr(A_CTL, 8'h04);
        rd(A_CTL, 8'hfe, 8'h84);
        wr(A_LO, 8'h55);
        rd(A_LO, 8'hff, 8'(r));
        wr(A_CTL, 8'h00);
        rd(A_CTL, 8'hfe, 8'h80);
        wr(A_CTL, 8'h01);
        wr(A_CTL, 8'h00);
        rd(A_CTL, 8'hff, 8'h00);
        $display("timing and lock test done");
        wr(A_CTL, 8'h80);
        wr(A_LO, 8'h00);
        wr(A_CTL, 8'h86);
        for (int j = 0; j < 4; j++) begin
            repeat (j) @(posedge pclk);
            wr(A_CTL, 8'h87);
            repeat (2) @(posedge pclk);
            check("clear wins", 16'(timeout_irq), 16'h0);
        end
        wr(A_CTL, 8'h81);
        wr(A_LO, 8'(r + 2));
        for (int i = 0; i < 2; i++) begin
            wr(A_CTL, i ? 8'h9c : 8'h8c);
            edge_t(1, n);
            edge_t(0, w);
            edge_t(1, b);
            check("high time", 16'(w), 16'(i ? 2 * r + 6 : 1));
            check("cycle", 16'(w + b), 16'((i + 1) * (2 * r + 6)));
            check("pin enable", 16'(wave_out_en), 16'h1);
            wr(A_CTL, i ? 8'h88 : 8'h84);
            repeat (3) @(posedge pclk);
            check("pin idle", 16'({wave_out_en, wave_out}), 16'h0);
            wr(A_CTL, 8'h80);
        end
        $display("waveform test done");
        wr(A_CTL, 8'h01);
        wr(A_LO, 8'h00);
        for (int i = 0; i < 5; i++) begin
            lfsr_q = nxt(lfsr_q);
            tv = (i == 4) ? lfsr_q[7:0] & 8'hfc : 8'h80 >> (i + i / 3 * 2);
            if (i == 0) tv = 8'h00;
            wr(A_TRM, tv);
            wr(A_CTL, 8'h06);
            cnt_irq(0);
            check("osc period", 16'(n), 16'(2 * lim(tv[7:2]) + 2));
            wr(A_CTL, 8'h01);
        end
        $display("oscillator test done");
        end_of_test();
    end
endmodule : tb_top
